/* src/drd_top.sv */
// Purpose: Diagnostic trouble code reporter: fault detection, DM1/DM2 framing.
// Assumes: Request decoding and CAN framing sit outside this block.
// Notes:   Summary of operation follows.
// Summary of operation
// - Supply checked against low/high limits, temperature against shutdown.
// - Mode setting suppresses all, drops blank-SPN codes, or sends normally.
// - A channel with its generation flag off adds nothing to DM1.
// - Trouble code bits 18..0 hold the SPN, least significant first.
// - Bits 23..19 hold the failure mode identifier.
// - Bit 24 is the conversion method bit, always zero.
// - Bits 31..25 hold the occurrence count.
// - The previously active list goes out only on request.
// - Previously active data is cleared only on a DM3 request or a write of the channel ID register.
// - Active data is cleared only on a DM11 request or a write of the channel ID register.
// - With any channel enabled, DM1 goes out every second.
// - With no active code, DM1 carries the no-active-faults content.
// - A code going inactive sends DM1 at once.
// - The last code going inactive sends an empty DM1 at once.
// - More than one active code makes the broadcast a BAM transfer.
// - A DM1 request with several codes gets a TP reply to the requester.
// - No DM1 broadcast within five seconds of power-up.
// - A code goes previously active on clearing, unless latched until DM11.
// - A fault must persist its delay before going active and counting.
// - Each active code sets its selected lamp in the lamp byte.
`timescale 1ns/1ps
module drd_top
	import drd_pkg::*;
#(
	parameter int TICK_CYCLES   = TICK_CYC,
	parameter int PERIOD_TICKS  = PERIOD_MS,
	parameter int HOLDOFF_TICKS = HOLDOFF_MS
)
(
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Register port.
	input  wire logic [7:0]   addr,
	input  wire logic [31:0]  wdata,
	input  wire logic         wr,
	input  wire logic         rd,
	output logic      [31:0]  rdata,
	// Measurements and fault inputs.
	input  wire logic [15:0]  supply_mv,
	input  wire logic [15:0]  temp_code,
	input  wire logic         lost_comm,
	// Received diagnostic requests.
	input  wire logic         req_valid,
	input  wire logic [1:0]   req_kind,
	input  wire logic [7:0]   req_src,
	// Message to the transmitter.
	output logic              tx_valid,
	input  wire logic         tx_ready,
	output logic      [1:0]   tx_msg,
	output logic      [7:0]   tx_dest,
	output logic      [7:0]   tx_lamp,
	output logic      [2:0]   tx_count,
	output logic      [NCH-1:0] tx_mask,
	output logic      [127:0] tx_dtc
);
	////////////////////////////////////////////////////////////////////////
	logic [1:0]     mode_r;
	logic [15:0]    uv_thr_r;
	logic [15:0]    ov_thr_r;
	logic [15:0]    temp_thr_r;
	logic           lc_s1_r;
	logic           lc_s2_r;
	logic [NCH-1:0] fault;
	logic [NCH-1:0] gen_v;
	logic [NCH-1:0] latch_v;
	logic [NCH-1:0] active;
	logic [NCH-1:0] prev;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;
	logic [NCH-1:0] incl_a;
	logic [NCH-1:0] incl_p;
	logic [1:0]     lamp_v [NCH];
	logic [15:0]    dly_v [NCH];
	logic [23:0]    id_v [NCH];
	logic [31:0]    dtc_v [NCH];
	logic [7:0]     lampc_a [NCH];
	logic [7:0]     lampc_p [NCH];
	logic           ch_hit;
	logic           tick;
	logic           clr_act;
	logic           clr_prev;
	logic           sending;

	assign ch_hit   = addr[7:6] == CH_REGION;
	assign clr_act  = req_valid && req_kind == REQ_DM11;
	assign clr_prev = req_valid && req_kind == REQ_DM3;
	assign sending  = mode_r != MODE_OFF;

	////////////////////////////////////////////////////////////////////////
	// Fault sources: undervoltage, overvoltage, temperature, lost link.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lc_s1_r <= 1'b0;
			lc_s2_r <= 1'b0;
		end
		else
		begin
			lc_s1_r <= lost_comm;
			lc_s2_r <= lc_s1_r;
		end
	end

	assign fault[0] = supply_mv < uv_thr_r;
	assign fault[1] = supply_mv > ov_thr_r;
	assign fault[2] = temp_code > temp_thr_r;
	assign fault[3] = lc_s2_r;

	////////////////////////////////////////////////////////////////////////
	// Global registers.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_r     <= MODE_NORMAL;
			uv_thr_r   <= RST_UV_THR;
			ov_thr_r   <= RST_OV_THR;
			temp_thr_r <= RST_TEMP_THR;
		end
		else if (wr)
		begin
			case (addr)
				A_CTRL:     mode_r     <= wdata[1:0];
				A_UV_THR:   uv_thr_r   <= wdata[15:0];
				A_OV_THR:   ov_thr_r   <= wdata[15:0];
				A_TEMP_THR: temp_thr_r <= wdata[15:0];
				default:    mode_r     <= mode_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel configuration, trouble code and lamp contribution.
	genvar i;
	for (i = 0; i < NCH; i++)
	begin : g_ch
		logic        gen_r;
		logic        latch_r;
		logic [1:0]  lamp_r;
		logic [15:0] dly_r;
		logic [18:0] spn_r;
		logic [4:0]  fmi_r;
		logic        sel;
		logic        spn_ok;
		logic [7:0]  lbit;
		drd_chan_if  cif();

		assign sel = ch_hit && wr && addr[5:4] == 2'(i);

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				gen_r   <= 1'b0;
				latch_r <= 1'b0;
				lamp_r  <= LAMP_AMBER;
				dly_r   <= RST_DELAY;
				spn_r   <= 19'(32'h0007ff00 + i);
				fmi_r   <= 5'h01;
			end
			else if (sel && addr[3:0] == CH_CFG)
			begin
				gen_r   <= wdata[0];
				latch_r <= wdata[1];
				lamp_r  <= wdata[3:2];
				dly_r   <= wdata[31:16];
			end
			else if (sel && addr[3:0] == CH_ID)
			begin
				spn_r <= wdata[18:0];
				fmi_r <= wdata[23:19];
			end
		end

		assign cif.tick     = tick;
		assign cif.fault    = fault[i];
		assign cif.gen_en   = gen_r;
		assign cif.latch    = latch_r;
		assign cif.delay    = dly_r;
		assign cif.clr_act  = clr_act;
		assign cif.clr_prev = clr_prev;
		assign cif.id_wr    = sel && addr[3:0] == CH_ID;

		drd_chan u_chan (
			.clk (clk),
			.rst (rst),
			.ch  (cif.chan)
		);

		assign spn_ok    = mode_r != MODE_NOBLANK || spn_r != BLANK_SPN;
		assign incl_a[i] = cif.active && gen_r && spn_ok;
		assign incl_p[i] = cif.prev && gen_r && spn_ok;
		assign lbit      = 8'(8'h01 << {~lamp_r, 1'b0});
		assign lampc_a[i] = incl_a[i] ? lbit : 8'h00;
		assign lampc_p[i] = incl_p[i] ? lbit : 8'h00;
		assign gen_v[i]  = gen_r;
		assign latch_v[i] = latch_r;
		assign lamp_v[i] = lamp_r;
		assign dly_v[i]  = dly_r;
		assign id_v[i]   = {fmi_r, spn_r};
		assign dtc_v[i]  = {cif.oc, 1'b0, fmi_r, spn_r};
		assign active[i] = cif.active;
		assign prev[i]   = cif.prev;
		assign rise[i]   = cif.rise;
		assign fall[i]   = cif.fall;
	end

	////////////////////////////////////////////////////////////////////////
	// Lamp bytes and code counts.
	logic [7:0] lamp_a;
	logic [7:0] lamp_p;
	logic [2:0] cnt_a;
	logic [2:0] cnt_p;

	always_comb
	begin
		lamp_a = 8'h00;
		lamp_p = 8'h00;
		cnt_a  = 3'h0;
		cnt_p  = 3'h0;
		for (int k = 0; k < NCH; k++)
		begin
			lamp_a = lamp_a | lampc_a[k];
			lamp_p = lamp_p | lampc_p[k];
			cnt_a  = cnt_a + 3'(incl_a[k]);
			cnt_p  = cnt_p + 3'(incl_p[k]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 1 ms tick, power-up hold-off and the one-second period.
	logic [23:0] tick_cnt_r;
	logic [15:0] hold_cnt_r;
	logic [15:0] per_cnt_r;
	logic        hold_done_r;
	logic        hold_end;
	logic        per_due;
	logic        any_gen;

	assign tick     = tick_cnt_r == 24'(TICK_CYCLES - 1);
	assign hold_end = tick && !hold_done_r &&
		hold_cnt_r == 16'(HOLDOFF_TICKS - 1);
	assign any_gen  = |gen_v;
	assign per_due  = hold_done_r && any_gen && tick &&
		per_cnt_r == 16'(PERIOD_TICKS - 1);

	always_ff @(posedge clk)
	begin
		if (rst || tick)
			tick_cnt_r <= 24'h000000;
		else
			tick_cnt_r <= tick_cnt_r + 24'h000001;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hold_cnt_r  <= 16'h0000;
			hold_done_r <= 1'b0;
		end
		else if (tick && !hold_done_r)
		begin
			hold_cnt_r  <= hold_cnt_r + 16'h0001;
			hold_done_r <= hold_end;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || !hold_done_r || !any_gen || per_due)
			per_cnt_r <= 16'h0000;
		else if (tick)
			per_cnt_r <= per_cnt_r + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Pending messages. A new event wins over the service of the old one.
	drd_tx_state_type st_r;
	logic       pend_b_r;
	logic       pend_r1_r;
	logic       pend_r2_r;
	logic [7:0] src1_r;
	logic [7:0] src2_r;
	logic       bcast_set;
	logic       load;
	logic       sel_r1;
	logic       sel_r2;

	assign bcast_set = sending && any_gen && (hold_end ||
		(hold_done_r && (per_due || |rise || |fall)));
	assign load   = st_r == ST_IDLE && (pend_b_r || pend_r1_r || pend_r2_r);
	assign sel_r1 = pend_r1_r;
	assign sel_r2 = !pend_r1_r && pend_r2_r;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pend_b_r  <= 1'b0;
			pend_r1_r <= 1'b0;
			pend_r2_r <= 1'b0;
		end
		else
		begin
			pend_b_r  <= bcast_set ||
				(pend_b_r && !(load && !sel_r1 && !sel_r2));
			pend_r1_r <= (sending && req_valid && req_kind == REQ_DM1) ||
				(pend_r1_r && !(load && sel_r1));
			pend_r2_r <= (sending && req_valid && req_kind == REQ_DM2) ||
				(pend_r2_r && !(load && sel_r2));
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			src1_r <= BCAST_ADDR;
			src2_r <= BCAST_ADDR;
		end
		else if (req_valid && req_kind == REQ_DM1)
			src1_r <= req_src;
		else if (req_valid && req_kind == REQ_DM2)
			src2_r <= req_src;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit hand-off: a snapshot held until the transmitter takes it.
	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= ST_IDLE;
		else
		begin
			case (st_r)
				ST_IDLE: if (load) st_r <= ST_SEND;
				ST_SEND: if (tx_ready) st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_msg   <= MSG_DM1;
			tx_dest  <= BCAST_ADDR;
			tx_lamp  <= 8'h00;
			tx_count <= 3'h0;
			tx_mask  <= '0;
			tx_dtc   <= '0;
		end
		else if (load)
		begin
			if (sel_r2)
			begin
				tx_msg   <= MSG_DM2;
				tx_dest  <= src2_r;
				tx_lamp  <= lamp_p;
				tx_count <= cnt_p;
				tx_mask  <= incl_p;
			end
			else
			begin
				if (cnt_a > 3'h1)
					tx_msg <= sel_r1 ? MSG_DM1_TP : MSG_DM1_BAM;
				else
					tx_msg <= MSG_DM1;
				tx_dest  <= sel_r1 ? src1_r : BCAST_ADDR;
				tx_lamp  <= lamp_a;
				tx_count <= cnt_a;
				tx_mask  <= incl_a;
			end
			for (int k = 0; k < NCH; k++)
				tx_dtc[32*k +: 32] <= (sel_r2 ? incl_p[k] : incl_a[k]) ?
					dtc_v[k] : 32'h00000000;
		end
	end

	assign tx_valid = st_r == ST_SEND;

	////////////////////////////////////////////////////////////////////////
	// Register read, answered in the following cycle.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata <= 32'h00000000;
		else if (rd)
		begin
			if (ch_hit)
			begin
				case (addr[3:0])
					CH_CFG:  rdata <= {dly_v[addr[5:4]], 12'h000,
						lamp_v[addr[5:4]], latch_v[addr[5:4]],
						gen_v[addr[5:4]]};
					CH_ID:   rdata <= {8'h00, id_v[addr[5:4]]};
					CH_DTC:  rdata <= dtc_v[addr[5:4]];
					default: rdata <= 32'h00000000;
				endcase
			end
			else
			begin
				case (addr)
					A_CTRL:     rdata <= {30'h0, mode_r};
					A_UV_THR:   rdata <= {16'h0000, uv_thr_r};
					A_OV_THR:   rdata <= {16'h0000, ov_thr_r};
					A_TEMP_THR: rdata <= {16'h0000, temp_thr_r};
					A_STATUS:   rdata <= {22'h0, tx_valid, hold_done_r,
						prev, active};
					default:    rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule : drd_top

/* common/drd_pkg.sv */
// Purpose: Shared constants and types of the diagnostic trouble code reporter.
// Assumes: 10 MHz system clock, 8-bit word-aligned register addresses.
// Notes:   Times are kept in their own unit; only the 1 ms tick is converted to cycles here.
package drd_pkg;
	localparam int          CLK_NS       = 100;
	localparam int          T_TICK_NS    = 1000000;
	localparam int          TICK_CYC     = T_TICK_NS / CLK_NS;
	localparam int          PERIOD_MS    = 1000;
	localparam int          HOLDOFF_MS   = 5000;
	localparam int          NCH          = 4;
	localparam logic [7:0]  BCAST_ADDR   = 8'hff;
	// Register map.
	localparam logic [7:0]  A_CTRL       = 8'h00;
	localparam logic [7:0]  A_UV_THR     = 8'h04;
	localparam logic [7:0]  A_OV_THR     = 8'h08;
	localparam logic [7:0]  A_TEMP_THR   = 8'h0c;
	localparam logic [7:0]  A_STATUS     = 8'h10;
	localparam logic [1:0]  CH_REGION    = 2'b01;
	localparam logic [3:0]  CH_CFG       = 4'h0;
	localparam logic [3:0]  CH_ID        = 4'h4;
	localparam logic [3:0]  CH_DTC       = 4'h8;
	// Reset values.
	localparam logic [15:0] RST_UV_THR   = 16'h2328;
	localparam logic [15:0] RST_OV_THR   = 16'h7530;
	localparam logic [15:0] RST_TEMP_THR = 16'h007d;
	localparam logic [15:0] RST_DELAY    = 16'h03e8;
	localparam logic [18:0] BLANK_SPN    = 19'h00000;
	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_NOBLANK = 2'b01,
		MODE_NORMAL  = 2'b10
	} drd_mode_type;
	typedef enum logic [1:0] {
		LAMP_MIL     = 2'b00,
		LAMP_RED     = 2'b01,
		LAMP_AMBER   = 2'b10,
		LAMP_PROTECT = 2'b11
	} drd_lamp_type;
	typedef enum logic [1:0] {
		REQ_DM1  = 2'b00,
		REQ_DM2  = 2'b01,
		REQ_DM3  = 2'b10,
		REQ_DM11 = 2'b11
	} drd_req_type;
	typedef enum logic [1:0] {
		MSG_DM1     = 2'b00,
		MSG_DM1_BAM = 2'b01,
		MSG_DM1_TP  = 2'b10,
		MSG_DM2     = 2'b11
	} drd_msg_type;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_SEND = 1'b1
	} drd_tx_state_type;
endpackage : drd_pkg

/* common/drd_chan_if.sv */
// Purpose: Signals between the reporter core and one fault channel.
// Assumes: Both ends run on the same clock.
// Notes:   The ctrl modport belongs to the core, chan to the channel.
`timescale 1ns/1ps
interface drd_chan_if;
	logic        tick;
	logic        fault;
	logic        gen_en;
	logic        latch;
	logic [15:0] delay;
	logic        clr_act;
	logic        clr_prev;
	logic        id_wr;
	logic        active;
	logic        prev;
	logic [6:0]  oc;
	logic        rise;
	logic        fall;
	modport chan (
		input  tick, fault, gen_en, latch, delay, clr_act, clr_prev, id_wr,
		output active, prev, oc, rise, fall
	);
	modport ctrl (
		output tick, fault, gen_en, latch, delay, clr_act, clr_prev, id_wr,
		input  active, prev, oc, rise, fall
	);
endinterface : drd_chan_if

/* src/drd_chan.sv */
// Purpose: One diagnostic channel: persistence timer, state, occurrence count.
// Assumes: tick is a one-cycle 1 ms enable.
// Notes:   rise and fall are one-cycle pulses on code state changes.
`timescale 1ns/1ps
module drd_chan
	import drd_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Core side.
	drd_chan_if.chan  ch
);
	logic [15:0] cnt_r;
	logic        persist;
	logic        drop;

	assign persist = ch.gen_en && ch.fault && !ch.active &&
		cnt_r == ch.delay;
	assign drop    = ch.active && (!ch.gen_en || ch.clr_act ||
		(!ch.fault && !ch.latch));

	always_ff @(posedge clk)
	begin
		if (rst || !ch.fault || ch.active || !ch.gen_en)
			cnt_r <= 16'h0000;
		else if (ch.tick && cnt_r != ch.delay)
			cnt_r <= cnt_r + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ch.active <= 1'b0;
		else if (persist)
			ch.active <= 1'b1;
		else if (drop)
			ch.active <= 1'b0;
	end

	// A code that just went inactive wins over a clear in the same cycle.
	always_ff @(posedge clk)
	begin
		if (rst)
			ch.prev <= 1'b0;
		else if (drop)
			ch.prev <= 1'b1;
		else if (persist || ch.clr_prev)
			ch.prev <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ch.oc <= 7'h00;
		else if (persist)
			ch.oc <= (ch.oc == 7'h7f) ? ch.oc : ch.oc + 7'h01;
		else if (ch.id_wr || (ch.clr_act && ch.active) ||
			(ch.clr_prev && ch.prev && !ch.active))
			ch.oc <= 7'h00;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ch.rise <= 1'b0;
			ch.fall <= 1'b0;
		end
		else
		begin
			ch.rise <= persist;
			ch.fall <= drop;
		end
	end
endmodule : drd_chan

/* tb/drd_checker.sv */
// Purpose: Port-level checks of the trouble code reporter.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Mode, last requester and DM2 demand are tracked from the ports.
`timescale 1ns/1ps
module drd_checker
	import drd_pkg::*;
#(
	parameter int TICK_CYCLES   = TICK_CYC,
	parameter int PERIOD_TICKS  = PERIOD_MS,
	parameter int HOLDOFF_TICKS = HOLDOFF_MS
)
(
	// Clock and reset.
	input wire logic           clk,
	input wire logic           rst,
	// Register writes.
	input wire logic [7:0]     addr,
	input wire logic [31:0]    wdata,
	input wire logic           wr,
	// Requests.
	input wire logic           req_valid,
	input wire logic [1:0]     req_kind,
	input wire logic [7:0]     req_src,
	// Transmit side.
	input wire logic           tx_valid,
	input wire logic           tx_ready,
	input wire logic [1:0]     tx_msg,
	input wire logic [7:0]     tx_dest,
	input wire logic [7:0]     tx_lamp,
	input wire logic [2:0]     tx_count,
	input wire logic [NCH-1:0] tx_mask,
	input wire logic [127:0]   tx_dtc
);
	localparam int HOLD = HOLDOFF_TICKS * TICK_CYCLES;
	int          hold_r;
	logic [1:0]  mode_r;
	logic [7:0]  src_r;
	logic        dm2_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk)
	begin
		if (rst)
			hold_r <= 0;
		else if (hold_r < HOLD)
			hold_r <= hold_r + 1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			mode_r <= 2'h2;
		else if (wr && addr == A_CTRL)
			mode_r <= wdata[1:0];
	end
	always_ff @(posedge clk)
	begin
		if (req_valid)
			src_r <= req_src;
	end
	// A DM2 may only go out while a DM2 request is outstanding.
	always_ff @(posedge clk)
	begin
		if (rst)
			dm2_r <= 1'h0;
		else if (req_valid && req_kind == REQ_DM2)
			dm2_r <= 1'h1;
		else if (tx_valid && tx_ready && tx_msg == MSG_DM2)
			dm2_r <= 1'h0;
	end
	sequence s_dm1_req;
		req_valid && req_kind == REQ_DM1 && mode_r != MODE_OFF;
	endsequence
	sequence s_reply;
		tx_valid && tx_dest == src_r && tx_msg != MSG_DM2;
	endsequence
	a_reply_start: assert property (s_dm1_req |-> ##[2:60] s_reply)
		else $error("DM1 request not answered to requester");
	a_hold_stable: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable({tx_msg, tx_dest, tx_lamp, tx_count, tx_mask, tx_dtc}))
		else $error("message changed before it was taken");
	a_cm_zero: assert property (tx_valid |->
		!(tx_dtc[24] | tx_dtc[56] | tx_dtc[88] | tx_dtc[120]))
		else $error("conversion method bit set");
	a_count_mask: assert property (tx_valid |->
		tx_count == $countones(tx_mask))
		else $error("code count differs from channel mask");
	a_bam_multi: assert property (tx_valid && tx_dest == BCAST_ADDR &&
		tx_msg != MSG_DM2 |-> (tx_count > 3'h1) == (tx_msg == MSG_DM1_BAM))
		else $error("broadcast framing does not match code count");
	a_tp_reply: assert property (tx_valid && tx_dest != BCAST_ADDR &&
		tx_msg != MSG_DM2 |-> (tx_count > 3'h1) == (tx_msg == MSG_DM1_TP))
		else $error("reply framing does not match code count");
	a_holdoff_quiet: assert property (tx_valid &&
		tx_dest == BCAST_ADDR |-> hold_r >= HOLD)
		else $error("broadcast inside power-up hold-off");
	a_dm2_requested: assert property (tx_valid &&
		tx_msg == MSG_DM2 |-> dm2_r)
		else $error("DM2 sent without request");
	a_empty_dark: assert property (tx_valid && tx_msg != MSG_DM2 &&
		tx_count == 3'h0 |-> tx_lamp == 8'h00)
		else $error("lamp lit with no active code");
endmodule : drd_checker
bind drd_top drd_checker #(.TICK_CYCLES(TICK_CYCLES),
	.PERIOD_TICKS(PERIOD_TICKS), .HOLDOFF_TICKS(HOLDOFF_TICKS)) u_chk (
	.clk, .rst, .addr, .wdata, .wr, .req_valid, .req_kind, .req_src,
	.tx_valid, .tx_ready, .tx_msg, .tx_dest, .tx_lamp, .tx_count,
	.tx_mask, .tx_dtc);

/* tb/drd_tx_model.sv */
// Purpose: Transmitter standing in for the network side.
// Assumes: Takes a message by raising tx_ready for one cycle.
// Notes:   stall sets how many cycles a waiting message is held off.
`timescale 1ns/1ps
module drd_tx_model
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst,
	// Handshake.
	input wire logic [1:0] stall,
	input wire logic       tx_valid,
	output logic           tx_ready
);
	logic [1:0] wait_r;
	always_ff @(posedge clk)
	begin
		if (rst || !tx_valid || tx_ready)
		begin
			tx_ready <= 1'h0;
			wait_r   <= 2'h0;
		end
		else if (wait_r == stall)
			tx_ready <= 1'h1;
		else
			wait_r <= wait_r + 2'h1;
	end
endmodule : drd_tx_model

/* tb/diagnostic_dtc_reporter_bench.sv */
// Purpose: Self-checking bench of the trouble code reporter.
// Assumes: Short tick, period and hold-off parameters.
// Notes:   Every taken message is queued with its cycle number.
`timescale 1ns/1ps
module diagnostic_dtc_reporter_bench import drd_pkg::*;;
	localparam int TC = 10;
	localparam int PT = 20;
	localparam int HT = 30;
	typedef struct packed {
		logic [31:0] t; logic [1:0] msg; logic [7:0] dest, lamp;
		logic [2:0] cnt; logic [3:0] mask; logic [127:0] dtc;
	} drd_rec_type;
	logic clk = 0, rst = 1, wr, rd, lost_comm, req_valid, tx_valid, tx_ready;
	logic [7:0] addr, req_src, tx_dest, tx_lamp, src;
	logic [31:0] wdata, rdata, seed, rv, v, t0;
	logic [15:0] supply_mv, temp_code;
	logic [1:0] req_kind, tx_msg, stall;
	logic [2:0] tx_count;
	logic [3:0] tx_mask;
	logic [127:0] tx_dtc;
	logic [18:0] spn3;
	drd_rec_type q[$], m;
	int cyc = 0, err_total = 0, compares = 0;
	logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h44,
		8'h74, 8'h20};
	logic [31:0] rx [9] = '{32'h2, 32'h2328, 32'h7530, 32'h7d, 32'h0,
		32'h03e80008, 32'h000fff00, 32'h000fff03, 32'h0};
	drd_top #(.TICK_CYCLES(TC), .PERIOD_TICKS(PT), .HOLDOFF_TICKS(HT)) u_dut (
		.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .supply_mv, .temp_code,
		.lost_comm, .req_valid, .req_kind, .req_src, .tx_valid, .tx_ready,
		.tx_msg, .tx_dest, .tx_lamp, .tx_count, .tx_mask, .tx_dtc);
	drd_tx_model u_tx (.clk, .rst, .stall, .tx_valid, .tx_ready);
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
	always @(negedge clk)
		if (tx_valid === 1'h1 && tx_ready === 1'h1)
			q.push_back({cyc, tx_msg, tx_dest, tx_lamp, tx_count, tx_mask, tx_dtc});
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] dw(logic [6:0] oc, logic [4:0] f,
		logic [18:0] s);
		return {oc, 1'h0, f, s};
	endfunction : dw
	task chk(input string nm, input logic [127:0] s, input logic [127:0] e);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task test_done;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wreg
	task rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		v = rdata;
	endtask : rreg
	task req(input logic [1:0] k);
		rv = rnd();
		src = {1'h0, rv[6:0]};
		@(posedge clk);
		req_valid <= 1'h1;
		req_kind  <= k;
		req_src   <= src;
		stall     <= rv[9:8];
		@(posedge clk);
		req_valid <= 1'h0;
	endtask : req
	task pop(input int lim);
		for (int i = 0; i < lim && q.size() == 0; i++)
			@(negedge clk);
		chk("message", q.size() != 0, 1'h1);
		m = (q.size() != 0) ? q.pop_front() : '0;
		// Leave on a rising edge so that the next stimulus lands on it.
		@(posedge clk);
	endtask : pop
	task cm(input logic [1:0] k, input logic [7:0] d, input logic [2:0] n,
		input logic [3:0] mk);
		chk("kind", m.msg, k);
		chk("dest", m.dest, d);
		chk("count", m.cnt, n);
		chk("mask", m.mask, mk);
	endtask : cm
	initial
	begin
		#(100 * 20000);
		err_total++;
		test_done;
	end
	initial
	begin
		{addr, wdata, wr, rd, lost_comm, req_valid, req_kind, req_src} = '0;
		{supply_mv, temp_code, stall, seed} = {16'h3000, 16'h0014, 2'h0, 32'h154dc};
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 9; i++)
		begin
			rreg(ra[i]);
			chk("reset value", v, rx[i]);
		end
		rv = rnd();
		spn3 = rv[18:0] | 19'h1;
		wreg(8'h40, 32'h00030001);
		wreg(8'h50, 32'h00000008);
		wreg(8'h60, 32'h00020005);
		wreg(8'h64, 32'h00800000);
		wreg(8'h70, 32'h0001000f);
		wreg(8'h74, {8'h00, 5'h03, spn3});
		pop(400);
		chk("first slot", m.t >= HT * TC && m.t <= HT * TC + 20, 1'h1);
		cm(MSG_DM1, BCAST_ADDR, 3'h0, 4'h0);
		t0 = m.t;
		pop(260);
		chk("period", m.t - t0 >= PT * TC - 5 && m.t - t0 <= PT * TC + 15, 1'h1);
		// Undervoltage on channel 0, which must persist 3 ticks.
		t0 = cyc;
		supply_mv <= 16'h1f40;
		pop(100);
		chk("persist", m.t - t0 >= 3 * TC, 1'h1);
		cm(MSG_DM1, BCAST_ADDR, 3'h1, 4'h1);
		chk("lamp", m.lamp, 8'h40);
		chk("code 0", m.dtc[31:0], dw(7'h1, 5'h01, 19'h7ff00));
		temp_code <= 16'h00c8;
		pop(60);
		cm(MSG_DM1_BAM, BCAST_ADDR, 3'h2, 4'h5);
		chk("lamp", m.lamp, 8'h50);
		chk("code 2", m.dtc[95:64], dw(7'h1, 5'h10, 19'h0));
		req(REQ_DM1);
		pop(30);
		cm(MSG_DM1_TP, src, 3'h2, 4'h5);
		wreg(A_CTRL, 32'h1);
		req(REQ_DM1);
		pop(30);
		cm(MSG_DM1, src, 3'h1, 4'h1);
		wreg(A_CTRL, 32'h2);
		temp_code <= 16'h0014;
		pop(20);
		cm(MSG_DM1, BCAST_ADDR, 3'h1, 4'h1);
		supply_mv <= 16'h3000;
		pop(20);
		cm(MSG_DM1, BCAST_ADDR, 3'h0, 4'h0);
		chk("lamp", m.lamp, 8'h00);
		rreg(A_STATUS);
		chk("status", v[7:0], 8'h50);
		req(REQ_DM2);
		pop(30);
		cm(MSG_DM2, src, 3'h2, 4'h5);
		chk("code 0", m.dtc[31:0], dw(7'h1, 5'h01, 19'h7ff00));
		req(REQ_DM3);
		rreg(A_STATUS);
		chk("status", v[7:0], 8'h00);
		rreg(8'h48);
		chk("code 0", v, dw(7'h0, 5'h01, 19'h7ff00));
		q.delete();
		pop(260);
		cm(MSG_DM1, BCAST_ADDR, 3'h0, 4'h0);
		lost_comm <= 1'h1;
		pop(60);
		cm(MSG_DM1, BCAST_ADDR, 3'h1, 4'h8);
		chk("lamp", m.lamp, 8'h01);
		chk("code 3", m.dtc[127:96], dw(7'h1, 5'h03, spn3));
		lost_comm <= 1'h0;
		repeat (20) @(posedge clk);
		rreg(A_STATUS);
		chk("latched", v[3:0], 4'h8);
		req(REQ_DM11);
		pop(30);
		cm(MSG_DM1, BCAST_ADDR, 3'h0, 4'h0);
		rreg(8'h78);
		chk("code 3", v, dw(7'h0, 5'h03, spn3));
		wreg(A_CTRL, 32'h0);
		q.delete();
		req(REQ_DM1);
		repeat (250) @(posedge clk);
		chk("silent", q.size(), 0);
		wreg(A_CTRL, 32'h2);
		supply_mv <= 16'h9c40;
		q.delete();
		pop(260);
		cm(MSG_DM1, BCAST_ADDR, 3'h0, 4'h0);
		test_done;
	end
endmodule : diagnostic_dtc_reporter_bench
